// ---- hw/sckm_regs.svh ----
// Purpose: constants for the system clock and mode control block
// Assumes: 100 MHz control clock
// Notes:   oscillators are modelled as enable levels and clock enables
`ifndef SCKM_REGS_SVH
`define SCKM_REGS_SVH
`define SCKM_SEL_W          3
`define SCKM_SEL_SUB        3'h7
`define SCKM_SEL_RESET      3'h7
`define SCKM_FAST_OSC_HZ    8000000
`define SCKM_SLOW_OSC_HZ    32000
`define SCKM_SYS_CLK_HZ     100000000
`define SCKM_STABLE_US      16
`define SCKM_STABLE_CYC     ((`SCKM_STABLE_US * `SCKM_SYS_CLK_HZ + 999999) / 1000000)
`define SCKM_FAST_HALF_CYC  ((`SCKM_SYS_CLK_HZ / `SCKM_FAST_OSC_HZ) / 2)
`define SCKM_SLOW_HALF_CYC  ((`SCKM_SYS_CLK_HZ / `SCKM_SLOW_OSC_HZ) / 2)
`endif

// ---- hw/sckm_pkg.sv ----
// Purpose: types for the system clock and mode control block
// Assumes: nothing
// Notes:   one-hot operating mode codes
package sckm_pkg;
   typedef enum logic [5:0] {
      SCKM_FAST       = 6'h01,
      SCKM_SLOW       = 6'h02,
      SCKM_SLEEP      = 6'h04,
      SCKM_IDLE_SUB   = 6'h08,
      SCKM_IDLE_BOTH  = 6'h10,
      SCKM_IDLE_HIGH  = 6'h20
   } sckm_mode_t;
endpackage

// ---- hw/sckm_top.sv ----
// Purpose: system clock source, divider and power mode control
// Assumes: clocks are produced as toggling levels registered on i_sys_clk
// Notes:   wake-up is a plain input; wake sources lie outside this block
//
// Behaviour
// [R01] Fast RC oscillator of 8 MHz, internal, sources the high clock.
// [R02] Slow RC oscillator of nominal 32 kHz sources the sub clock.
// [R03] Select codes 000 to 110 give high clock divided by 1 to 64.
// [R04] Select code 111 runs system clock from the sub clock, slow mode.
// [R05] In slow mode fast oscillator runs or stops per its enable bit.
// [R06] Six modes: fast, slow, sleep and three idle modes.
// [R07] Halt with both idle enables low enters sleep; system, high and sub clocks stop.
// [R08] In sleep slow oscillator runs only while watchdog is enabled.
// [R09] Halt with fast low, slow high: sub only, sysclk only for 111.
// [R10] Halt with both enables high: all clocks keep running.
// [R11] Halt with fast high, slow low: high only, sysclk for 000-110.
// [R12] Running modes keep sub clock and slow oscillator, feed watchdog.
// [R13] Stable flag clears on enable or frequency change, sets when stable.
// [R14] Clock switching never shortens a high phase; a low phase across a select switch can last only 3 i_sys_clk cycles.
// [R15] CPU gives one-cycle halt; idle enables sampled at that moment.
`timescale 1ns/100ps
`include "sckm_regs.svh"
module sckm_top
   import sckm_pkg::*;
#(
   parameter int STABLE_CYC    = `SCKM_STABLE_CYC,
   parameter int FAST_HALF_CYC = `SCKM_FAST_HALF_CYC,
   parameter int SLOW_HALF_CYC = `SCKM_SLOW_HALF_CYC
) (
   // Clock, reset, enable
   input  wire logic                   i_sys_clk,
   input  wire logic                   i_srst,
   input  wire logic                   i_ce,
   // Control bits
   input  wire logic [`SCKM_SEL_W-1:0] i_sysclk_select,
   input  wire logic                   i_fast_osc_enable,
   input  wire logic                   i_fast_freq_change,
   input  wire logic                   i_fast_idle_enable,
   input  wire logic                   i_slow_idle_enable,
   input  wire logic                   i_watchdog_enable,
   // CPU events
   input  wire logic                   i_halt,
   input  wire logic                   i_wake,
   // Clocks out
   output logic                        o_system_clock,
   output logic                        o_high_clock,
   output logic                        o_sub_clock,
   output logic                        o_slow_osc_clock,
   // Status
   output logic                        o_fast_rc_osc_on,
   output logic                        o_slow_rc_osc_on,
   output logic                        o_fast_osc_stable_flag,
   output logic                        o_cpu_run,
   output sckm_mode_t                  o_mode
);
   initial begin
      if (STABLE_CYC < 1 || FAST_HALF_CYC < 1 || SLOW_HALF_CYC < 1
          || STABLE_CYC > 65535 || FAST_HALF_CYC > 65535 || SLOW_HALF_CYC > 65535) begin
         $error("sckm_top: counts must lie between 1 and 65535");
      end
   end

   // ======================================================
   // Mode control
   sckm_mode_t mode;
   logic       halted;
   logic       sub_sel;
   assign halted  = !(mode == SCKM_FAST || mode == SCKM_SLOW);
   assign sub_sel = (i_sysclk_select == `SCKM_SEL_SUB);

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         mode <= SCKM_SLOW;
      end else if (i_ce) begin
         if (!halted && i_halt) begin
            unique case ({i_fast_idle_enable, i_slow_idle_enable}) // R15
               2'b00: mode <= SCKM_SLEEP;      // R07
               2'b01: mode <= SCKM_IDLE_SUB;   // R09
               2'b11: mode <= SCKM_IDLE_BOTH;  // R10
               2'b10: mode <= SCKM_IDLE_HIGH;  // R11
            endcase
         end else if (halted ? i_wake : 1'b1) begin
            mode <= sub_sel ? SCKM_SLOW : SCKM_FAST; // R04 R06
         end
      end
   end

   // ======================================================
   // Oscillator enables
   logic next_fast_on;
   logic next_slow_on;
   always_comb begin
      unique case (mode)
         SCKM_FAST:      next_fast_on = 1'b1;
         SCKM_SLOW:      next_fast_on = i_fast_osc_enable; // R05
         SCKM_IDLE_BOTH: next_fast_on = 1'b1;              // R10
         SCKM_IDLE_HIGH: next_fast_on = 1'b1;              // R11
         default:        next_fast_on = 1'b0;              // R07 R09
      endcase
      next_slow_on = (mode == SCKM_SLEEP) ? i_watchdog_enable : 1'b1; // R08 R12
   end

   logic fast_on_q;
   logic [15:0] stab_cnt;
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         fast_on_q              <= 1'b0;
         stab_cnt               <= 16'h0000;
         o_fast_osc_stable_flag <= 1'b0;
      end else if (i_ce) begin
         fast_on_q <= next_fast_on;
         if ((next_fast_on && !fast_on_q) || i_fast_freq_change || !next_fast_on) begin
            stab_cnt               <= 16'h0000; // R13
            o_fast_osc_stable_flag <= 1'b0;     // R13
         end else if (!o_fast_osc_stable_flag) begin
            if (int'(stab_cnt) >= STABLE_CYC - 1) begin
               o_fast_osc_stable_flag <= 1'b1;  // R13
            end else begin
               stab_cnt <= stab_cnt + 16'h0001;
            end
         end
      end
   end

   // ======================================================
   // Oscillator models as toggling enables
   logic [15:0] fast_cnt;
   logic [15:0] slow_cnt;
   logic        fast_osc;
   logic        slow_osc;
   logic        fast_tick;
   logic        slow_tick;
   logic        fast_run;
   // A fast high half always completes, so a fast stop never leaves a short pulse
   assign fast_run  = (fast_on_q && o_fast_osc_stable_flag) || fast_osc;
   assign fast_tick = fast_run && (int'(fast_cnt) == FAST_HALF_CYC - 1);
   assign slow_tick = o_slow_rc_osc_on && (int'(slow_cnt) == SLOW_HALF_CYC - 1);

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         fast_cnt <= 16'h0000;
         fast_osc <= 1'b0;
      end else if (i_ce) begin
         if (!fast_run || fast_tick) begin
            fast_cnt <= 16'h0000;
         end else begin
            fast_cnt <= fast_cnt + 16'h0001;
         end
         if (fast_tick) begin
            fast_osc <= !fast_osc; // R01
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         slow_cnt <= 16'h0000;
         slow_osc <= 1'b0;
      end else if (i_ce) begin
         if (!o_slow_rc_osc_on || slow_tick) begin
            slow_cnt <= 16'h0000;
         end else begin
            slow_cnt <= slow_cnt + 16'h0001;
         end
         if (!o_slow_rc_osc_on) begin
            slow_osc <= 1'b0;
         end else if (slow_tick) begin
            slow_osc <= !slow_osc; // R02
         end
      end
   end

   // ======================================================
   // High clock divider chain
   logic [5:0] div_cnt;
   logic       fast_rise;
   assign fast_rise = fast_tick && !fast_osc;
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         div_cnt <= 6'h00;
      end else if (i_ce && fast_rise) begin
         div_cnt <= div_cnt + 6'h01;
      end
   end

   function automatic logic div_tap(input logic [2:0] sel, input logic [5:0] cnt,
                                    input logic osc);
      div_tap = (sel == 3'h0) ? osc : cnt[sel - 3'h1];
   endfunction

   // ======================================================
   // Glitch-free system clock switch, changes only while low
   logic [2:0] cur_sel;
   logic       cand;
   logic       cand_q;
   logic       sys_gate;
   assign cand = (cur_sel == `SCKM_SEL_SUB) ? slow_osc
                 : div_tap(cur_sel, div_cnt, fast_osc); // R03 R04
   always_comb begin
      unique case (mode)
         SCKM_SLEEP:     sys_gate = 1'b0;              // R07
         SCKM_IDLE_SUB:  sys_gate = (cur_sel == `SCKM_SEL_SUB);  // R09
         SCKM_IDLE_HIGH: sys_gate = (cur_sel != `SCKM_SEL_SUB);  // R11
         default:        sys_gate = 1'b1;              // R10 R12
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         cur_sel        <= `SCKM_SEL_RESET;
         cand_q         <= 1'b1;
         o_system_clock <= 1'b0;
      end else if (i_ce) begin
         if (!o_system_clock && cur_sel != i_sysclk_select) begin
            cur_sel <= i_sysclk_select; // R14
            cand_q  <= 1'b1;            // R14
         end else begin
            cand_q <= cand;
            // Rise only on a source rising edge, fall with the source
            if (o_system_clock) begin
               o_system_clock <= cand;                       // R14
            end else begin
               o_system_clock <= cand && !cand_q && sys_gate; // R14
            end
         end
      end
   end

   // Phase length watch for the switch
   logic [15:0] sys_phase_cnt;
   logic        sys_clk_q;
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         sys_phase_cnt <= 16'hffff;
         sys_clk_q     <= 1'b0;
      end else if (i_ce) begin
         sys_clk_q <= o_system_clock;
         if (o_system_clock != sys_clk_q) begin
            sys_phase_cnt <= 16'h0001;
         end else if (sys_phase_cnt != 16'hffff) begin
            sys_phase_cnt <= sys_phase_cnt + 16'h0001;
         end
      end
   end

   // ======================================================
   // Peripheral clocks and status outputs
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         o_high_clock     <= 1'b0;
         o_sub_clock      <= 1'b0;
         o_slow_osc_clock <= 1'b0;
         o_fast_rc_osc_on <= 1'b0;
         o_slow_rc_osc_on <= 1'b1;
         o_cpu_run        <= 1'b0;
         o_mode           <= SCKM_SLOW;
      end else if (i_ce) begin
         o_high_clock     <= fast_osc;
         o_sub_clock      <= slow_osc && (mode != SCKM_SLEEP)
                             && (mode != SCKM_IDLE_HIGH); // R07 R11 R12
         o_slow_osc_clock <= slow_osc;                    // R08 R12
         o_fast_rc_osc_on <= next_fast_on;
         o_slow_rc_osc_on <= next_slow_on;
         o_cpu_run        <= !halted;                     // R06
         o_mode           <= mode;
      end
   end

   // ======================================================
   // Checks
   chk_sleep_entry: assert property (@(posedge i_sys_clk) disable iff (i_srst) // R07
      i_ce && !halted && i_halt && !i_fast_idle_enable && !i_slow_idle_enable
      |=> mode == SCKM_SLEEP) else $error("sleep not entered");
   chk_idle_sub: assert property (@(posedge i_sys_clk) disable iff (i_srst) // R09
      i_ce && !halted && i_halt && !i_fast_idle_enable && i_slow_idle_enable
      |=> mode == SCKM_IDLE_SUB) else $error("idle sub not entered");
   chk_idle_both: assert property (@(posedge i_sys_clk) disable iff (i_srst) // R10
      i_ce && !halted && i_halt && i_fast_idle_enable && i_slow_idle_enable
      |=> mode == SCKM_IDLE_BOTH) else $error("idle both not entered");
   chk_idle_high: assert property (@(posedge i_sys_clk) disable iff (i_srst) // R11
      i_ce && !halted && i_halt && i_fast_idle_enable && !i_slow_idle_enable
      |=> mode == SCKM_IDLE_HIGH) else $error("idle high not entered");
   chk_sleep_slow_osc: assert property (@(posedge i_sys_clk) disable iff (i_srst) // R08
      i_ce && mode == SCKM_SLEEP |=> o_slow_rc_osc_on == $past(i_watchdog_enable))
      else $error("slow osc wrong in sleep");
   chk_run_slow_osc: assert property (@(posedge i_sys_clk) disable iff (i_srst) // R12
      i_ce && !halted |=> o_slow_rc_osc_on) else $error("slow osc off while running");
   chk_stable_clear: assert property (@(posedge i_sys_clk) disable iff (i_srst) // R13
      i_ce && i_fast_freq_change |=> !o_fast_osc_stable_flag)
      else $error("stable flag not cleared");
   chk_sleep_sysclk: assert property (@(posedge i_sys_clk) disable iff (i_srst) // R07
      i_ce && mode == SCKM_SLEEP && !o_system_clock |=> !o_system_clock)
      else $error("system clock runs in sleep");
   chk_sys_min_phase: assert property (@(posedge i_sys_clk) disable iff (i_srst) // R14
      i_ce && o_system_clock != sys_clk_q |-> int'(sys_phase_cnt) >= FAST_HALF_CYC)
      else $error("system clock phase shortened");
   chk_idle_high_sub: assert property (@(posedge i_sys_clk) disable iff (i_srst) // R11
      i_ce && mode == SCKM_IDLE_HIGH |=> !o_sub_clock)
      else $error("sub clock runs in idle high");
   chk_halt_held: assert property (@(posedge i_sys_clk) disable iff (i_srst) // R06
      i_ce && halted && !i_wake |=> mode == $past(mode))
      else $error("halted mode left without wake");
   chk_slow_fast_osc: assert property (@(posedge i_sys_clk) disable iff (i_srst) // R05
      i_ce && mode == SCKM_SLOW |=> o_fast_rc_osc_on == $past(i_fast_osc_enable))
      else $error("fast osc enable ignored in slow mode");
   cov_sleep: cover property (@(posedge i_sys_clk) mode == SCKM_SLEEP);
   cov_idle_both: cover property (@(posedge i_sys_clk) mode == SCKM_IDLE_BOTH);
   cov_fast_run: cover property (@(posedge i_sys_clk) mode == SCKM_FAST && o_system_clock);
   cov_stable: cover property (@(posedge i_sys_clk) $rose(o_fast_osc_stable_flag));
   cov_idle_sub: cover property (@(posedge i_sys_clk) mode == SCKM_IDLE_SUB);
endmodule

// ---- tb/sckm_top_tb.sv ----
// Purpose: self-checking bench for sckm_top
// Assumes: short oscillator and settle counts set by parameter
// Notes:   clock activity judged by toggle counts
`timescale 1ns/100ps
module sckm_top_tb;
   import sckm_pkg::*;
   localparam int STB = 4;
   localparam int FH  = 2;
   localparam int SH  = 8;
   // =========================================
   // Signals
   logic       i_sys_clk = 0, i_srst = 1, i_ce = 1, i_halt = 0, i_wake = 0;
   logic [2:0] i_sysclk_select = 3'h7;
   logic       i_fast_osc_enable = 0, i_fast_freq_change = 0, i_watchdog_enable = 0;
   logic       i_fast_idle_enable = 0, i_slow_idle_enable = 0;
   logic       o_system_clock, o_high_clock, o_sub_clock, o_slow_osc_clock;
   logic       o_fast_rc_osc_on, o_slow_rc_osc_on, o_fast_osc_stable_flag, o_cpu_run;
   sckm_mode_t o_mode;
   int         bad_count = 0, cmp_count = 0, cyc = 0, run = 0, p, tg[4];
   logic       sc_q = 0;
   always #5 i_sys_clk = ~i_sys_clk;
   sckm_top #(.STABLE_CYC(STB), .FAST_HALF_CYC(FH), .SLOW_HALF_CYC(SH)) dut (
      .i_sys_clk              (i_sys_clk),
      .i_srst                 (i_srst),
      .i_ce                   (i_ce),
      .i_sysclk_select        (i_sysclk_select),
      .i_fast_osc_enable      (i_fast_osc_enable),
      .i_fast_freq_change     (i_fast_freq_change),
      .i_fast_idle_enable     (i_fast_idle_enable),
      .i_slow_idle_enable     (i_slow_idle_enable),
      .i_watchdog_enable      (i_watchdog_enable),
      .i_halt                 (i_halt),
      .i_wake                 (i_wake),
      .o_system_clock         (o_system_clock),
      .o_high_clock           (o_high_clock),
      .o_sub_clock            (o_sub_clock),
      .o_slow_osc_clock       (o_slow_osc_clock),
      .o_fast_rc_osc_on       (o_fast_rc_osc_on),
      .o_slow_rc_osc_on       (o_slow_rc_osc_on),
      .o_fast_osc_stable_flag (o_fast_osc_stable_flag),
      .o_cpu_run              (o_cpu_run),
      .o_mode                 (o_mode)
   );
   // =========================================
   // Tasks
   task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic tick(int n);
      repeat (n) @(negedge i_sys_clk);
   endtask
   task automatic sample(int n);
      logic [3:0] pv, cu;
      tg = '{default: 0};
      pv = {o_system_clock, o_high_clock, o_sub_clock, o_slow_osc_clock};
      repeat (n) begin
         tick(1);
         cu = {o_system_clock, o_high_clock, o_sub_clock, o_slow_osc_clock};
         for (int i = 0; i < 4; i++) tg[i] += (cu[i] !== pv[i]);
         pv = cu;
      end
   endtask
   task automatic sys_period(output int per);
      int k;
      k = 0;
      per = 0;
      while (o_system_clock !== 1'b0 && k < 1000) begin tick(1); k++; end
      while (o_system_clock !== 1'b1 && k < 1000) begin tick(1); k++; end
      while (o_system_clock !== 1'b0 && k < 1000) begin tick(1); k++; per++; end
      while (o_system_clock !== 1'b1 && k < 1000) begin tick(1); k++; per++; end
   endtask
   task automatic pulse_halt(logic fi, logic si);
      i_fast_idle_enable = fi;
      i_slow_idle_enable = si;
      i_halt = 1;
      tick(1);
      i_halt = 0;
      tick(20);
   endtask
   // =========================================
   // Timeout and phase watch
   always @(posedge i_sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   always @(negedge i_sys_clk) begin
      if (i_srst) begin
         run <= -100000;
      end else if (o_system_clock !== sc_q) begin
         if (run > 0) check("sys_phase", run >= FH, 1);
         run <= 1;
      end else begin
         run <= run + 1;
      end
      sc_q <= o_system_clock;
   end
   // =========================================
   // Main sequence
   initial begin
      logic fi, si, wd;
      tick(3);
      i_srst = 0;
      tick(2);
      check("mode_rst", o_mode, SCKM_SLOW);
      check("fast_on_rst", o_fast_rc_osc_on, 0);
      check("slow_on_rst", o_slow_rc_osc_on, 1);
      check("flag_rst", o_fast_osc_stable_flag, 0);
      i_ce = 0;
      pulse_halt(0, 0);
      check("ce_freeze", o_mode, SCKM_SLOW);
      check("ce_cpu_run", o_cpu_run, 1);
      i_ce = 1;
      tick(2);
      sys_period(p);
      sys_period(p);
      check("sub_period", p, 2 * SH);
      sample(40);
      check("sub_runs", tg[1] != 0, 1);
      check("slow_osc_runs", tg[0] != 0, 1);
      i_fast_osc_enable = 1;
      tick(2);
      check("flag_start", o_fast_osc_stable_flag, 0);
      tick(STB + 4);
      check("flag_set", o_fast_osc_stable_flag, 1);
      check("fast_on", o_fast_rc_osc_on, 1);
      i_fast_freq_change = 1;
      tick(1);
      i_fast_freq_change = 0;
      tick(1);
      check("flag_clr", o_fast_osc_stable_flag, 0);
      tick(STB + 4);
      check("flag_reset", o_fast_osc_stable_flag, 1);
      for (int s = 0; s < 7; s++) begin
         i_sysclk_select = 3'(s);
         sys_period(p);
         sys_period(p);
         check("fast_period", 8'(p >> 2), 8'(FH >> 1 << s));
         check("mode_fast", o_mode, SCKM_FAST);
      end
      i_sysclk_select = 3'h7;
      sys_period(p);
      sys_period(p);
      check("mode_slow", o_mode, SCKM_SLOW);
      i_fast_osc_enable = 0;
      tick(8);
      check("fast_off", o_fast_rc_osc_on, 0);
      sample(40);
      check("high_off", tg[2] != 0, 0);
      i_fast_osc_enable = 1;
      tick(STB + 8);
      for (int h = 0; h < 8; h++) begin
         {wd, si, fi} = 3'(h);
         i_watchdog_enable = wd;
         i_sysclk_select = wd ? 3'h7 : 3'h0;
         sys_period(p);
         sys_period(p);
         pulse_halt(fi, si);
         check("halt_mode", o_mode, {fi & ~si, fi & si, ~fi & si, ~fi & ~si, 2'h0});
         check("cpu_off", o_cpu_run, 0);
         sample(40);
         check("high_run", tg[2] != 0, fi);
         check("sub_run", tg[1] != 0, si);
         check("sys_run", tg[3] != 0, wd ? si : fi);
         check("slow_osc_clk", tg[0] != 0, fi | si | wd);
         check("slow_osc_on", o_slow_rc_osc_on, fi | si | wd);
         pulse_halt(~fi, ~si);
         check("halt_ignored", o_mode, {fi & ~si, fi & si, ~fi & si, ~fi & ~si, 2'h0});
         i_wake = 1;
         tick(1);
         i_wake = 0;
         tick(STB + 8);
         check("wake_mode", o_mode, wd ? SCKM_SLOW : SCKM_FAST);
         check("cpu_on", o_cpu_run, 1);
      end
      tally_and_finish();
   end
endmodule
